// [design/ict_carrier_gen.sv]
// Carrier generator: high and low phase lengths counted in base clock pulses.
module ict_carrier_gen #(
    parameter int CW = 8
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Control.
    input wire logic i_restart,
    input wire logic i_run,
    input wire logic i_base_en,
    input wire logic [CW-1:0] i_high_len,
    input wire logic [CW-1:0] i_low_len,
    // Carrier.
    output logic o_level,
    output logic o_tick
);
    import ict_pkg::*;

    logic [CW-1:0] phase_cnt;
    wire [CW-1:0] phase_lim = o_level ? i_high_len : i_low_len;
    wire phase_end = i_run & i_base_en & (phase_cnt == phase_lim);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_cnt <= '0;
            o_level <= 1'b1;
            o_tick <= 1'b0;
        end else if (i_restart) begin
            phase_cnt <= '0;
            o_level <= 1'b1;
            o_tick <= 1'b0;
        end else begin
            o_tick <= phase_end & ~o_level;
            if (phase_end) begin
                phase_cnt <= '0;
                o_level <= ~o_level;
            end else if (i_run & i_base_en) begin
                phase_cnt <= phase_cnt + 1'b1;
            end
        end
    end

endmodule : ict_carrier_gen

// [design/ict_infrared_timer.sv]
// Infrared carrier timer top: register slave, transmit modulator, receive capture.

// Contract
// - Enabled transmit pin idles at polarity level.
// - Data one sends carrier, inverted by polarity.
// - Data zero holds pin at idle level, except with envelope select 10b.
// - Transmit starts on enable and transmit direction.
// - Settings sampled at start and each reload.
// - Down count; at zero reload, sample, flag.
// - Each interval lasts modulation time plus one.
// - Envelope select 01b/10b drives envelope pin.
// - Envelope pin is data xor polarity.
// - Envelope 01b modulated, 10b unmodulated carrier.
// - Edge select picks qualified receive edges.
// - Receive counts up from zero after event.
// - Fine select counts base clock, else carriers.
// - Event stores pin level into modulation bit.
// - Event copies timer into modulation time.
// - Event clears timer only with auto clear.
// - Receive wrap before event sets overflow flag.
// - Receive runs until direction or enable change.
// - Burst mode zero keeps standard capture.
module ict_infrared_timer #(
    parameter int BASE_DIV = 1
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Avalon-MM slave.
    input wire logic [ict_pkg::ICT_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [ict_pkg::ICT_DW-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [ict_pkg::ICT_DW-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Infrared pins.
    input wire logic i_infrared_receive_pin,
    output logic o_infrared_transmit_pin,
    output logic o_envelope_out_pin,
    // Interrupt request.
    output logic o_irq
);
    import ict_pkg::*;

    // ************************************************************
    // State.
    // ************************************************************
    ict_ctrl_t ctrl;
    logic [ICT_TW-1:0] carrier_setting;
    logic [ICT_TW-1:0] modulation_time;
    logic [ICT_TW-1:0] infrared_timer_value;
    logic [ICT_TW-1:0] burst_pulses;
    logic [ICT_TW-1:0] car_s;
    logic data_s;
    logic pol_s;
    logic timer_flag;
    logic timer_overflow_flag;
    logic rx_started;
    logic tx_run_q;
    logic rx_run_q;
    logic rd_done;
    logic [ICT_DW-1:0] rd_mux;

    logic [ICT_TW-1:0] next_timer;
    logic next_tx_pin;
    logic next_env_pin;

    // ************************************************************
    // Base clock divider.
    // ************************************************************
    localparam int DIV_W = (BASE_DIV > 1) ? $clog2(BASE_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BASE_DIV - 1);
    logic [DIV_W-1:0] div_cnt;
    wire base_en = (div_cnt == DIV_LAST);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_cnt <= '0;
        end else if (base_en) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // ************************************************************
    // Bus decode.
    // ************************************************************
    wire sel_ctrl = (i_avs_address == ICT_OFS_CTRL);
    wire sel_status = (i_avs_address == ICT_OFS_STATUS);
    wire sel_carrier = (i_avs_address == ICT_OFS_CARRIER);
    wire sel_modtime = (i_avs_address == ICT_OFS_MODTIME);
    wire sel_timer = (i_avs_address == ICT_OFS_TIMER);
    wire sel_burst = (i_avs_address == ICT_OFS_BURST);
    wire wr_ctrl = i_avs_write & sel_ctrl;
    wire wr_status = i_avs_write & sel_status;
    wire wr_carrier = i_avs_write & sel_carrier;
    wire wr_modtime = i_avs_write & sel_modtime;

    function automatic logic [ICT_DW-1:0] merge_bytes(
        input logic [ICT_DW-1:0] old_v,
        input logic [ICT_DW-1:0] new_v,
        input logic [3:0] be
    );
        logic [ICT_DW-1:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    wire [ICT_DW-1:0] ctrl_wide = {{(ICT_DW-ICT_CTRL_W){1'b0}}, ctrl};
    wire [ICT_DW-1:0] ctrl_merged = merge_bytes(ctrl_wide, i_avs_writedata, i_avs_byteenable);
    wire [ICT_DW-1:0] car_merged = merge_bytes({16'h0000, carrier_setting},
                                               i_avs_writedata, i_avs_byteenable);
    wire [ICT_DW-1:0] mt_merged = merge_bytes({16'h0000, modulation_time},
                                              i_avs_writedata, i_avs_byteenable);
    wire [ICT_DW-1:0] clr_mask = i_avs_byteenable[0] ? i_avs_writedata : ICT_RD_ZERO;
    wire clr_timer_flag = wr_status & clr_mask[ICT_ST_TIMER_FLAG];
    wire clr_ovf_flag = wr_status & clr_mask[ICT_ST_OVF_FLAG];

    // ************************************************************
    // Operating state.
    // ************************************************************
    wire tx_run = ctrl.module_enable & ctrl.direction_select;
    wire rx_run = ctrl.module_enable & ~ctrl.direction_select;
    wire tx_start = tx_run & ~tx_run_q;
    wire rx_start = rx_run & ~rx_run_q;
    wire tx_active = tx_run & ~tx_start;
    wire rx_active = rx_run & ~rx_start;

    // ************************************************************
    // Carrier and receive edge.
    // ************************************************************
    logic car_level;
    logic car_tick;
    ict_edge_t rx_edge;
    wire [ICT_TW-1:0] car_use = tx_run ? car_s : carrier_setting;

    ict_carrier_gen #(
        .CW(ICT_CW)
    ) u_carrier (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_restart(tx_start | rx_start),
        .i_run(ctrl.module_enable),
        .i_base_en(base_en),
        .i_high_len(car_use[ICT_CAR_HI_LSB +: ICT_CW]),
        .i_low_len(car_use[ICT_CW-1:0]),
        .o_level(car_level),
        .o_tick(car_tick)
    );

    ict_rx_edge u_rx_edge (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_infrared_receive_pin),
        .o_edge(rx_edge)
    );

    // ************************************************************
    // Event qualification.
    // ************************************************************
    wire edge_hit = (ctrl.capture_edge_select == ICT_EDGE_FALL) ? rx_edge.fall :
                    (ctrl.capture_edge_select == ICT_EDGE_RISE) ? rx_edge.rise :
                    (rx_edge.rise | rx_edge.fall);
    wire qual = rx_active & edge_hit;
    wire capture = qual & rx_started & ~ctrl.burst_count_mode;
    wire burst_hit = qual & ctrl.burst_count_mode;
    wire cnt_tick = ctrl.fine_count_select ? base_en : car_tick;
    wire timer_zero = (infrared_timer_value == ICT_TIMER_ZERO);
    wire timer_full = (infrared_timer_value == ICT_TIMER_MAX);
    wire tx_reload = tx_active & car_tick & timer_zero;
    wire rx_wrap = rx_active & rx_started & cnt_tick & timer_full & ~qual;
    wire clear_on_event = ~rx_started | (ctrl.capture_auto_clear & capture);

    // ************************************************************
    // Timer next value.
    // ************************************************************
    always_comb begin
        next_timer = infrared_timer_value;
        if (tx_start) begin
            next_timer = modulation_time;
        end else if (tx_active & car_tick) begin
            if (timer_zero) begin
                next_timer = modulation_time;
            end else begin
                next_timer = infrared_timer_value - ICT_TIMER_ONE;
            end
        end else if (rx_start) begin
            next_timer = ICT_TIMER_ZERO;
        end else if (rx_active) begin
            if (qual & clear_on_event) begin
                next_timer = ICT_TIMER_ZERO;
            end else if (rx_started & cnt_tick) begin
                next_timer = infrared_timer_value + ICT_TIMER_ONE;
            end
        end
    end

    // ************************************************************
    // Pin levels.
    // ************************************************************
    wire car_out = car_level ^ pol_s;
    wire mod_out = data_s ? car_out : pol_s;
    wire env_on = (ctrl.envelope_select == ICT_ENV_MOD) |
                  (ctrl.envelope_select == ICT_ENV_UNMOD);

    always_comb begin
        next_tx_pin = 1'b0;
        next_env_pin = 1'b0;
        if (!ctrl.module_enable) begin
            next_tx_pin = 1'b0;
            next_env_pin = 1'b0;
        end else if (tx_active) begin
            case (ctrl.envelope_select)
                ICT_ENV_UNMOD: begin
                    next_tx_pin = car_out;
                end
                ICT_ENV_MOD: begin
                    next_tx_pin = mod_out;
                end
                ICT_ENV_OFF: begin
                    next_tx_pin = mod_out;
                end
                default: begin
                    next_tx_pin = mod_out;
                end
            endcase
            next_env_pin = env_on & (data_s ^ pol_s);
        end else begin
            next_tx_pin = ctrl.tx_polarity;
            next_env_pin = 1'b0;
        end
    end

    // ************************************************************
    // Run tracking and transmit sampling.
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_run_q <= 1'b0;
            rx_run_q <= 1'b0;
            car_s <= ICT_CARRIER_RST;
            data_s <= 1'b0;
            pol_s <= 1'b0;
        end else begin
            tx_run_q <= tx_run;
            rx_run_q <= rx_run;
            if (tx_start | tx_reload) begin
                car_s <= carrier_setting;
                data_s <= ctrl.modulation_bit;
                pol_s <= ctrl.tx_polarity;
            end
        end
    end

    // ************************************************************
    // Timer, capture and burst counting.
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            infrared_timer_value <= ICT_TIMER_ZERO;
            rx_started <= 1'b0;
            burst_pulses <= ICT_TIMER_ZERO;
        end else begin
            infrared_timer_value <= next_timer;
            if (rx_start | ~rx_run) begin
                rx_started <= 1'b0;
            end else if (qual) begin
                rx_started <= 1'b1;
            end
            if (rx_start) begin
                burst_pulses <= ICT_TIMER_ZERO;
            end else if (burst_hit) begin
                burst_pulses <= burst_pulses + ICT_TIMER_ONE;
            end
        end
    end

    // ************************************************************
    // Software registers; hardware capture wins over a write.
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl <= ICT_CTRL_RST;
            carrier_setting <= ICT_CARRIER_RST;
            modulation_time <= ICT_MODTIME_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= ict_ctrl_t'(ctrl_merged[ICT_CTRL_W-1:0]);
            end
            if (capture) begin
                ctrl.modulation_bit <= rx_edge.rise;
            end
            if (wr_carrier) begin
                carrier_setting <= car_merged[ICT_TW-1:0];
            end
            if (capture) begin
                modulation_time <= infrared_timer_value;
            end else if (wr_modtime) begin
                modulation_time <= mt_merged[ICT_TW-1:0];
            end
        end
    end

    // ************************************************************
    // Sticky flags; a set in the clearing cycle wins.
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            timer_flag <= 1'b0;
            timer_overflow_flag <= 1'b0;
        end else begin
            if (tx_reload) begin
                timer_flag <= 1'b1;
            end else if (clr_timer_flag) begin
                timer_flag <= 1'b0;
            end
            if (rx_wrap) begin
                timer_overflow_flag <= 1'b1;
            end else if (clr_ovf_flag) begin
                timer_overflow_flag <= 1'b0;
            end
        end
    end

    assign o_irq = ctrl.timer_interrupt_enable &
                   (timer_flag | timer_overflow_flag);

    // ************************************************************
    // Read path and pin outputs.
    // ************************************************************
    wire [ICT_DW-1:0] status_word = {29'h0000_0000, rx_started,
                                     timer_overflow_flag, timer_flag};

    assign rd_mux = sel_ctrl ? ctrl_wide :
                    sel_status ? status_word :
                    sel_carrier ? {16'h0000, carrier_setting} :
                    sel_modtime ? {16'h0000, modulation_time} :
                    sel_timer ? {16'h0000, infrared_timer_value} :
                    sel_burst ? {16'h0000, burst_pulses} :
                    ICT_RD_ZERO;

    assign o_avs_waitrequest = i_avs_read & ~rd_done;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rd_done <= 1'b0;
            o_avs_readdata <= ICT_RD_ZERO;
            o_infrared_transmit_pin <= 1'b0;
            o_envelope_out_pin <= 1'b0;
        end else begin
            rd_done <= i_avs_read & ~rd_done;
            if (i_avs_read & ~rd_done) begin
                o_avs_readdata <= rd_mux;
            end
            o_infrared_transmit_pin <= next_tx_pin;
            o_envelope_out_pin <= next_env_pin;
        end
    end

endmodule : ict_infrared_timer

// [design/ict_rx_edge.sv]
// Receive pin synchroniser and edge detector.
module ict_rx_edge (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Pin.
    input wire logic i_pin,
    // Result.
    output ict_pkg::ict_edge_t o_edge
);
    import ict_pkg::*;

    logic sync1;
    logic sync2;
    logic prev;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            prev <= 1'b1;
        end else begin
            sync1 <= i_pin;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    assign o_edge.level = sync2;
    assign o_edge.rise = sync2 & ~prev;
    assign o_edge.fall = ~sync2 & prev;

endmodule : ict_rx_edge

// [pkg/ict_pkg.sv]
// Shared constants, register map and types of the infrared carrier timer.
package ict_pkg;

    // ************************************************************
    // Widths.
    // ************************************************************
    localparam int ICT_TW = 16;
    localparam int ICT_AW = 8;
    localparam int ICT_DW = 32;
    localparam int ICT_CW = 8;

    // ************************************************************
    // Register byte offsets.
    // ************************************************************
    localparam logic [ICT_AW-1:0] ICT_OFS_CTRL = 8'h00;
    localparam logic [ICT_AW-1:0] ICT_OFS_STATUS = 8'h04;
    localparam logic [ICT_AW-1:0] ICT_OFS_CARRIER = 8'h08;
    localparam logic [ICT_AW-1:0] ICT_OFS_MODTIME = 8'h0c;
    localparam logic [ICT_AW-1:0] ICT_OFS_TIMER = 8'h10;
    localparam logic [ICT_AW-1:0] ICT_OFS_BURST = 8'h14;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int ICT_CTRL_W = 12;
    localparam int ICT_ST_TIMER_FLAG = 0;
    localparam int ICT_ST_OVF_FLAG = 1;
    localparam int ICT_ST_RX_STARTED = 2;
    localparam int ICT_CAR_HI_LSB = 8;

    // ************************************************************
    // Reset values and fixed counts.
    // ************************************************************
    localparam logic [ICT_CTRL_W-1:0] ICT_CTRL_RST = 12'h000;
    localparam logic [ICT_TW-1:0] ICT_CARRIER_RST = 16'h0000;
    localparam logic [ICT_TW-1:0] ICT_MODTIME_RST = 16'h0000;
    localparam logic [ICT_TW-1:0] ICT_TIMER_ZERO = 16'h0000;
    localparam logic [ICT_TW-1:0] ICT_TIMER_MAX = 16'hffff;
    localparam logic [ICT_TW-1:0] ICT_TIMER_ONE = 16'h0001;
    localparam logic [ICT_DW-1:0] ICT_RD_ZERO = 32'h0000_0000;

    // ************************************************************
    // Selector encodings.
    // ************************************************************
    localparam logic [1:0] ICT_ENV_OFF = 2'b00;
    localparam logic [1:0] ICT_ENV_MOD = 2'b01;
    localparam logic [1:0] ICT_ENV_UNMOD = 2'b10;
    localparam logic [1:0] ICT_EDGE_FALL = 2'b00;
    localparam logic [1:0] ICT_EDGE_RISE = 2'b01;

    // ************************************************************
    // Control register layout, most significant field first.
    // ************************************************************
    typedef struct packed {
        logic timer_interrupt_enable;
        logic burst_count_mode;
        logic capture_auto_clear;
        logic fine_count_select;
        logic [1:0] capture_edge_select;
        logic [1:0] envelope_select;
        logic tx_polarity;
        logic modulation_bit;
        logic direction_select;
        logic module_enable;
    } ict_ctrl_t;

    // ************************************************************
    // Edge detector results.
    // ************************************************************
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } ict_edge_t;

endpackage : ict_pkg

// [sim/ict_assertions.sv]
// Checker of the infrared carrier timer port behaviour, with its bind.
module ict_assertions #(
    parameter int BASE_DIV = 1
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register bus.
    input wire logic [ict_pkg::ICT_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [ict_pkg::ICT_DW-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [ict_pkg::ICT_DW-1:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // Pins and interrupt.
    input wire logic i_infrared_receive_pin,
    input wire logic o_infrared_transmit_pin,
    input wire logic o_envelope_out_pin,
    input wire logic o_irq
);
    import ict_pkg::*;
    // ********
    // Shadow of the control register, taken from bus writes.
    // ********
    ict_ctrl_t c;
    wire ctrl_wr = i_avs_write && (i_avs_address == ICT_OFS_CTRL);
    wire [3:0] next_hi = i_avs_byteenable[1] ? i_avs_writedata[11:8] : c[11:8];
    wire [7:0] next_lo = i_avs_byteenable[0] ? i_avs_writedata[7:0] : c[7:0];
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            c <= ICT_CTRL_RST;
        end else if (ctrl_wr) begin
            c <= {next_hi, next_lo};
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_rd_wait;
        i_avs_read && o_avs_waitrequest;
    endsequence
    AST_WR_NOWAIT: assert property (i_avs_write |-> !o_avs_waitrequest)
        else $error("write was stalled");
    AST_RD_ONE_WAIT: assert property (s_rd_wait |=> !o_avs_waitrequest)
        else $error("read took more than one wait cycle");
    AST_OFF_PINS: assert property ((!c.module_enable) [*3] |->
        !o_infrared_transmit_pin && !o_envelope_out_pin) else $error("pins active while off");
    AST_RX_IDLE: assert property ((c.module_enable && !c.direction_select &&
        $stable(c.tx_polarity)) [*3] |-> o_infrared_transmit_pin == c.tx_polarity)
        else $error("receive idle level wrong");
    AST_ENV_OFF: assert property ((!(^c.envelope_select)) [*3] |-> !o_envelope_out_pin)
        else $error("envelope pin active with envelope off");
    AST_IRQ_MASK: assert property ((!c.timer_interrupt_enable) [*2] |-> !o_irq)
        else $error("interrupt while masked");
    AST_IRQ_HOLD: assert property (o_irq && !i_avs_write |=> o_irq)
        else $error("interrupt dropped without software");
    AST_IRQ_CAUSE: assert property ($rose(o_irq) |-> c.timer_interrupt_enable)
        else $error("interrupt rose while disabled");
endmodule : ict_assertions

bind ict_infrared_timer ict_assertions #(.BASE_DIV(BASE_DIV)) chk_u (
    .i_clk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_infrared_receive_pin,
    .o_infrared_transmit_pin, .o_envelope_out_pin, .o_irq
);

// [sim/ict_ir_far.sv]
// Behavioural infrared emitter and detector facing the timer pins.
module ict_ir_far (
    // Clock.
    input wire logic i_clk,
    // Timer pins.
    input wire logic i_tx_pin,
    output logic o_rx_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    int edges = 0;
    logic last_tx = 1'b0;
    initial o_rx_pin = 1'b1;
    // Counts light pulses seen by the emitter.
    always @(posedge i_clk) begin
        last_tx <= i_tx_pin;
        if (i_tx_pin && !last_tx) begin
            edges <= edges + 1;
        end
    end
    // Detector output idles high and changes just after an edge.
    task automatic lvl(input logic v);
        @(posedge i_clk);
        o_rx_pin <= v;
    endtask : lvl
endmodule : ict_ir_far

// [sim/testbench.sv]
// Self-checking bench of the infrared carrier timer.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ict_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, q, v;
    logic wreq, tx, env, irq, rx;
    logic ac = 1'b1;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    int tbase = 0;
    int e, n;
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    ict_infrared_timer #(.BASE_DIV(1)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .i_infrared_receive_pin(rx), .o_infrared_transmit_pin(tx),
        .o_envelope_out_pin(env), .o_irq(irq));
    ict_ir_far far_u (.i_clk(i_clk), .i_tx_pin(tx), .o_rx_pin(rx));
    // ********
    // Tasks.
    // ********
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        num_checks++;
        if (x !== s) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic run(input int k);
        repeat (k) @(posedge i_clk);
    endtask : run
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int k;
        @(posedge i_clk);
        adr <= a;
        wd <= d;
        wr <= we;
        rd <= !we;
        for (k = 0; k < 20; k++) begin
            @(posedge i_clk);
            if (wreq === 1'b0) break;
        end
        r = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (k == 20) begin
            miscompares++;
            conclude();
        end
    endtask : acc
    task automatic rxev(input logic lv, input logic first);
        far_u.lvl(lv);
        e = cyc - tbase;
        if (first || ac) begin
            tbase = cyc;
        end
        run(50);
        if (!first) begin
            acc(1'b0, ICT_OFS_MODTIME, 32'h0, q);
            chk("capture", 32'h1, q >= e - 1 && q <= e + 1);
            acc(1'b0, ICT_OFS_CTRL, 32'h0, q);
            chk("rx level", lv, q[2]);
        end
    endtask : rxev
    // ********
    // Tests.
    // ********
    initial begin
        run(3);
        i_sys_rst <= 1'b0;
        acc(1'b0, ICT_OFS_CTRL, 32'h0, q);
        chk("ctrl reset", 32'h0, q);
        acc(1'b1, 8'h18, 32'hffff, q);
        acc(1'b0, 8'h18, 32'h0, q);
        chk("unmapped", 32'h0, q);
        for (int p = 0; p < 2; p++) begin
            acc(1'b1, ICT_OFS_CTRL, 32'h1 + 8 * p, q);
            run(5);
            chk("idle level", p, tx);
        end
        $display("test registers and idle done");
        acc(1'b1, ICT_OFS_CARRIER, 32'h0, q);
        acc(1'b1, ICT_OFS_MODTIME, 32'h1, q);
        for (int i = 0; i < 5; i++) begin
            v = 32'h803 + 4 * (i % 2) + 8 * ((i / 2) % 2) + ((i == 4) ? 32'h20 : 32'h10);
            if (i == 2) acc(1'b1, ICT_OFS_CTRL, v & 32'hffe, q);
            acc(1'b1, ICT_OFS_CTRL, v, q);
            run(10);
            e = far_u.edges;
            run(80);
            n = (i % 2 == 1 || i == 4) ? 40 : 0;
            chk("carrier", 32'h1, far_u.edges - e >= n - 1 && far_u.edges - e <= n + 1);
            if (n == 0) chk("idle tx", v[3], tx);
            chk("envelope", v[2] ^ v[3], env);
            acc(1'b0, ICT_OFS_STATUS, 32'h0, q);
            chk("timer flag", 32'h1, q[0]);
            chk("irq", 32'h1, irq);
            acc(1'b1, ICT_OFS_CTRL, 32'h800, q);
            run(3);
            acc(1'b1, ICT_OFS_STATUS, 32'h3, q);
            run(1);
            chk("irq clear", 32'h0, irq);
            chk("off pin", 32'h0, tx);
        end
        $display("test transmit done");
        acc(1'b1, ICT_OFS_CTRL, 32'hbc1, q);
        rxev(1'b0, 1'b1);
        rxev(1'b1, 1'b0);
        rxev(1'b0, 1'b0);
        acc(1'b1, ICT_OFS_CTRL, 32'h9c1, q);
        ac = 1'b0;
        rxev(1'b1, 1'b0);
        rxev(1'b0, 1'b0);
        acc(1'b0, ICT_OFS_MODTIME, 32'h0, q);
        v = q;
        acc(1'b1, ICT_OFS_CTRL, 32'h901, q);
        far_u.lvl(1'b1);
        run(20);
        acc(1'b0, ICT_OFS_MODTIME, 32'h0, q);
        chk("rise ignored", v, q);
        acc(1'b1, ICT_OFS_CTRL, 32'hdc1, q);
        far_u.lvl(1'b0);
        run(20);
        acc(1'b0, ICT_OFS_BURST, 32'h0, q);
        chk("burst count", 32'h1, q);
        acc(1'b0, ICT_OFS_MODTIME, 32'h0, q);
        chk("burst no capture", v, q);
        $display("test receive done");
        run(65600);
        acc(1'b0, ICT_OFS_STATUS, 32'h0, q);
        chk("overflow", 32'h1, q[1]);
        chk("irq overflow", 32'h1, irq);
        acc(1'b1, ICT_OFS_CTRL, 32'h800, q);
        acc(1'b1, ICT_OFS_STATUS, 32'h3, q);
        run(1);
        chk("irq cleared", 32'h0, irq);
        $display("test overflow done");
        conclude();
    end
endmodule : testbench
